// ### verilog/bat_pkg.sv
// Purpose: Shared constants, types and decoding for the byte ALU and bit test block.
// Assumes: 14-bit instruction words, 8-bit data, 128 file registers, APB with 32-bit data.
// Notes:   Summary of operation follows.
// Summary of operation
// [RQ1] Literal add: acc plus literal into acc.
// [RQ2] Register add: acc plus file register, flags.
// [RQ3] Destination bit 0 selects acc, 1 file.
// [RQ4] Literal AND into acc, zero flag only.
// [RQ5] Register AND to destination, zero flag only.
// [RQ6] Bit clear forces indexed bit to zero.
// [RQ7] Bit set forces indexed bit to one.
// [RQ8] Test zero skips next when bit clear.
// [RQ9] Test one skips next when bit set.
// [RQ10] Word holds address, destination, bit index.
// [RQ11] Zero flag set when result is zero.
// [RQ12] Carry from bit 7, half carry bit 3.
package bat_pkg;

    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int INSTR_W = 14;
    localparam int BIT_W   = 3;
    localparam int CYC_W   = 16;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFS_INSTR  = 8'h00;
    localparam logic [7:0] OFS_ACC    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FADDR  = 8'h0c;
    localparam logic [7:0] OFS_FDATA  = 8'h10;
    localparam logic [7:0] OFS_CYCLES = 8'h14;

    // Status register bit positions.
    localparam int ST_CARRY = 0;
    localparam int ST_HALF  = 1;
    localparam int ST_ZERO  = 2;
    localparam int ST_SKIP  = 3;

    // Instruction field positions.
    localparam int IW_DEST    = 7;
    localparam int IW_BIT_LSB = 7;
    localparam int IW_LIT_W   = 8;

    // Opcode fields, compared against the top bits of the word.
    localparam logic [5:0] OPC_ADD_REG   = 6'h07;
    localparam logic [5:0] OPC_AND_REG   = 6'h05;
    localparam logic [3:0] OPC_BIT_CLR   = 4'h4;
    localparam logic [3:0] OPC_BIT_SET   = 4'h5;
    localparam logic [3:0] OPC_TEST_ZERO = 4'h6;
    localparam logic [3:0] OPC_TEST_ONE  = 4'h7;
    localparam logic [4:0] OPC_ADD_LIT   = 5'h1f;
    localparam logic [5:0] OPC_AND_LIT   = 6'h39;

    // Reset values.
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [13:0] INSTR_RST = 14'h0000;
    localparam logic [6:0]  FADDR_RST = 7'h00;
    localparam logic [15:0] CYC_RST   = 16'h0000;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD_LITERAL_TO_ACC,
        OP_ADD_ACC_WITH_REG,
        OP_AND_LITERAL_WITH_ACC,
        OP_AND_ACC_WITH_REG,
        OP_BIT_CLEAR,
        OP_BIT_SET,
        OP_TEST_SKIP_IF_ZERO,
        OP_TEST_SKIP_IF_ONE
    } bat_op_t;

    function automatic bat_op_t bat_decode(input logic [13:0] iw);
        bat_op_t op;
        op = OP_NONE;
        if (iw[13:8] == OPC_ADD_REG)
            op = OP_ADD_ACC_WITH_REG;
        else if (iw[13:8] == OPC_AND_REG)
            op = OP_AND_ACC_WITH_REG;
        else if (iw[13:10] == OPC_BIT_CLR)
            op = OP_BIT_CLEAR;
        else if (iw[13:10] == OPC_BIT_SET)
            op = OP_BIT_SET;
        else if (iw[13:10] == OPC_TEST_ZERO)
            op = OP_TEST_SKIP_IF_ZERO;
        else if (iw[13:10] == OPC_TEST_ONE)
            op = OP_TEST_SKIP_IF_ONE;
        else if (iw[13:9] == OPC_ADD_LIT)
            op = OP_ADD_LITERAL_TO_ACC;
        else if (iw[13:8] == OPC_AND_LIT)
            op = OP_AND_LITERAL_WITH_ACC;
        return op;
    endfunction

endpackage

// ### verilog/bat_file_ram.sv
// Purpose: File register array with one write port and one registered read port.
// Assumes: Single clock; read data appear one edge after the address.
// Notes:   Contents are not reset, as in a real register file.
`timescale 1ns/1ps
module bat_file_ram #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // A read of the address being written returns the old contents.
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule

// ### verilog/bat_alu_top.sv
// Purpose: Executes byte add/AND and bit set/clear/test instructions written over APB.
// Assumes: APB master on MCLK; one instruction per write to the instruction register.
// Notes:   Unsupported opcodes only count a cycle and, unless skipped, answer with PSLVERR.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module bat_alu_top (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DONE
    } bat_state_t;

    bat_state_t        state;
    logic [13:0]       instr;
    logic [7:0]        acc;
    logic              flag_carry;
    logic              flag_half;
    logic              flag_zero;
    logic              skip_pending;
    logic [6:0]        faddr;
    logic [15:0]       cycles;
    logic              is_instr;
    logic              slverr;

    logic              start;
    logic              sel_instr;
    logic              sel_acc;
    logic              sel_status;
    logic              sel_faddr;
    logic              sel_fdata;
    logic              sel_cycles;
    logic              mapped;

    logic [7:0]        mem_rdata;
    logic              mem_we;
    logic [6:0]        mem_waddr;
    logic [7:0]        mem_wdata;
    logic [6:0]        mem_raddr;

    bat_pkg::bat_op_t  op;
    logic [7:0]        operand;
    logic [7:0]        bit_mask;
    logic [2:0]        bit_idx;
    logic              tested_bit;
    logic [8:0]        sum_full;
    logic [4:0]        sum_low;
    logic [7:0]        result;
    logic              exec_go;
    logic              discard;
    logic              wr_acc;
    logic              wr_file;
    logic              upd_carry;
    logic              upd_zero;
    logic              set_skip;
    logic              unsupported;

    // Access decode; a request is taken only in the first access cycle.
    assign start      = PSEL && PENABLE && (state == ST_IDLE);
    assign sel_instr  = (PADDR == bat_pkg::OFS_INSTR);
    assign sel_acc    = (PADDR == bat_pkg::OFS_ACC);
    assign sel_status = (PADDR == bat_pkg::OFS_STATUS);
    assign sel_faddr  = (PADDR == bat_pkg::OFS_FADDR);
    assign sel_fdata  = (PADDR == bat_pkg::OFS_FDATA);
    assign sel_cycles = (PADDR == bat_pkg::OFS_CYCLES);
    assign mapped     = sel_instr | sel_acc | sel_status | sel_faddr | sel_fdata | sel_cycles;

    // Both answers decode the state register, so each stands for exactly one cycle.
    assign PREADY  = (state == ST_DONE);
    assign PSLVERR = (state == ST_DONE) && slverr;

    // The file address comes straight from the write data so that the operand is ready in EXEC.
    assign mem_raddr = (PWRITE && sel_instr) ? PWDATA[6:0] : faddr;

    bat_file_ram #(
        .ADDR_W (bat_pkg::FADDR_W),
        .DATA_W (bat_pkg::DATA_W)
    ) u_ram (
        .clk     (MCLK),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // Bit operations take their index from the three bits just above the file address.
    assign op         = bat_pkg::bat_decode(instr);
    assign bit_idx    = instr[bat_pkg::IW_BIT_LSB +: bat_pkg::BIT_W]; // RQ10
    assign bit_mask   = 8'h01 << bit_idx; // RQ6 RQ7
    assign tested_bit = mem_rdata[bit_idx]; // RQ8 RQ9
    assign operand    = ((op == bat_pkg::OP_ADD_LITERAL_TO_ACC) || (op == bat_pkg::OP_AND_LITERAL_WITH_ACC))
                        ? instr[bat_pkg::IW_LIT_W-1:0] : mem_rdata;
    assign sum_full   = {1'b0, acc} + {1'b0, operand};
    assign sum_low    = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};

    // A skipped instruction becomes a no-operation cycle.
    assign discard = (state == ST_EXEC) && is_instr && skip_pending;
    assign exec_go = (state == ST_EXEC) && is_instr && !skip_pending;

    // Words outside the eight supported kinds are flagged here and change no register but the cycle count.
    always_comb begin
        result      = 8'h00;
        wr_acc      = 1'b0;
        wr_file     = 1'b0;
        upd_carry   = 1'b0;
        upd_zero    = 1'b0;
        set_skip    = 1'b0;
        unsupported = 1'b0;
        unique case (op)
            bat_pkg::OP_ADD_LITERAL_TO_ACC: begin
                result    = sum_full[7:0]; // RQ1
                wr_acc    = 1'b1; // RQ1
                upd_carry = 1'b1; // RQ1
                upd_zero  = 1'b1; // RQ1
            end
            bat_pkg::OP_ADD_ACC_WITH_REG: begin
                result    = sum_full[7:0]; // RQ2
                wr_acc    = !instr[bat_pkg::IW_DEST]; // RQ3
                wr_file   = instr[bat_pkg::IW_DEST]; // RQ3
                upd_carry = 1'b1; // RQ2
                upd_zero  = 1'b1; // RQ2
            end
            bat_pkg::OP_AND_LITERAL_WITH_ACC: begin
                result   = acc & operand; // RQ4
                wr_acc   = 1'b1; // RQ4
                upd_zero = 1'b1; // RQ4
            end
            bat_pkg::OP_AND_ACC_WITH_REG: begin
                result   = acc & operand; // RQ5
                wr_acc   = !instr[bat_pkg::IW_DEST]; // RQ3
                wr_file  = instr[bat_pkg::IW_DEST]; // RQ3
                upd_zero = 1'b1; // RQ5
            end
            bat_pkg::OP_BIT_CLEAR: begin
                result  = mem_rdata & ~bit_mask; // RQ6
                wr_file = 1'b1; // RQ6
            end
            bat_pkg::OP_BIT_SET: begin
                result  = mem_rdata | bit_mask; // RQ7
                wr_file = 1'b1; // RQ7
            end
            bat_pkg::OP_TEST_SKIP_IF_ZERO: begin
                set_skip = !tested_bit; // RQ8
            end
            bat_pkg::OP_TEST_SKIP_IF_ONE: begin
                set_skip = tested_bit; // RQ9
            end
            bat_pkg::OP_NONE: begin
                unsupported = 1'b1;
            end
        endcase
    end

    // File writes come either from software through the data window or from execution.
    assign mem_we    = (start && PWRITE && sel_fdata) || (exec_go && wr_file);
    assign mem_waddr = exec_go ? instr[bat_pkg::FADDR_W-1:0] : faddr; // RQ10
    assign mem_wdata = exec_go ? result : PWDATA[7:0];

    // Instruction writes and window reads wait one extra cycle for the registered file read.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state    <= ST_IDLE;
            is_instr <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        is_instr <= PWRITE && sel_instr;
                        if ((PWRITE && sel_instr) || (!PWRITE && sel_fdata)) begin
                            state <= ST_EXEC;
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_EXEC: begin
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            instr <= bat_pkg::INSTR_RST;
        end else if (start && PWRITE && sel_instr) begin
            instr <= PWDATA[bat_pkg::INSTR_W-1:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            faddr <= bat_pkg::FADDR_RST;
        end else if (start && PWRITE && sel_faddr) begin
            faddr <= PWDATA[bat_pkg::FADDR_W-1:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            acc <= bat_pkg::ACC_RST;
        end else if (exec_go && wr_acc) begin
            acc <= result;
        end else if (start && PWRITE && sel_acc) begin
            acc <= PWDATA[7:0];
        end
    end

    // Software writes to status and execution never fall in the same cycle.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            flag_carry <= 1'b0;
            flag_half  <= 1'b0;
            flag_zero  <= 1'b0;
        end else if (exec_go) begin
            if (upd_carry) begin
                flag_carry <= sum_full[8]; // RQ12
                flag_half  <= sum_low[4]; // RQ12
            end
            if (upd_zero) begin
                flag_zero <= (result == 8'h00); // RQ11
            end
        end else if (start && PWRITE && sel_status) begin
            flag_carry <= PWDATA[bat_pkg::ST_CARRY];
            flag_half  <= PWDATA[bat_pkg::ST_HALF];
            flag_zero  <= PWDATA[bat_pkg::ST_ZERO];
        end
    end

    // The discarded instruction cannot itself set a skip, so set and clear never meet.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            skip_pending <= 1'b0;
        end else if (exec_go && set_skip) begin
            skip_pending <= 1'b1; // RQ8 RQ9
        end else if (discard) begin
            skip_pending <= 1'b0; // RQ8 RQ9
        end
    end

    // Every taken instruction, executed or discarded, costs one instruction cycle.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cycles <= bat_pkg::CYC_RST;
        end else if ((state == ST_EXEC) && is_instr) begin
            cycles <= cycles + 16'h0001; // RQ8 RQ9
        end else if (start && PWRITE && sel_cycles) begin
            cycles <= bat_pkg::CYC_RST;
        end
    end

    // An unmapped address is refused at once; an instruction is judged only when it executes.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            slverr <= 1'b0;
        end else if (start) begin
            slverr <= !mapped;
        end else if ((state == ST_EXEC) && is_instr) begin
            slverr <= exec_go && unsupported;
        end
    end

    // Read data are caught at the taken edge, or one cycle later for the file window.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (start) begin
            PRDATA <= 32'h0000_0000;
            if (!PWRITE) begin
                if (sel_instr) begin
                    PRDATA <= {18'h00000, instr};
                end else if (sel_acc) begin
                    PRDATA <= {24'h000000, acc};
                end else if (sel_status) begin
                    PRDATA <= {28'h0000000, skip_pending, flag_zero, flag_half, flag_carry};
                end else if (sel_faddr) begin
                    PRDATA <= {25'h0000000, faddr};
                end else if (sel_cycles) begin
                    PRDATA <= {16'h0000, cycles};
                end
            end
        end else if ((state == ST_EXEC) && !is_instr) begin
            PRDATA <= {24'h000000, mem_rdata};
        end
    end

endmodule

// ### dv/bat_alu_properties.sv
// Purpose: Port-level checks of the APB timing and error answers of bat_alu_top.
// Assumes: One clock, synchronous reset, the hand-over register map.
// Notes:   Sees only the top module ports and is attached by bind.
`timescale 1ns/1ps
module bat_alu_properties (
    input wire logic        MCLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    default clocking props_cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    logic en_q;
    logic start;
    logic mapped;
    logic instr_wr;
    logic slow;
    logic good_op;
    always_ff @(posedge MCLK) begin
        en_q <= PENABLE;
    end
    // The first access cycle of each transfer is where the block takes it.
    assign start = PSEL && PENABLE && !en_q;
    assign mapped = PADDR inside {bat_pkg::OFS_INSTR, bat_pkg::OFS_ACC, bat_pkg::OFS_STATUS,
                                  bat_pkg::OFS_FADDR, bat_pkg::OFS_FDATA, bat_pkg::OFS_CYCLES};
    assign instr_wr = start && PWRITE && PADDR == bat_pkg::OFS_INSTR;
    assign slow = instr_wr || (start && !PWRITE && PADDR == bat_pkg::OFS_FDATA);
    assign good_op = PWDATA[13:12] == 2'b01 || PWDATA[13:8] == bat_pkg::OPC_ADD_REG
                     || PWDATA[13:8] == bat_pkg::OPC_AND_REG || PWDATA[13:9] == bat_pkg::OPC_ADD_LIT
                     || PWDATA[13:8] == bat_pkg::OPC_AND_LIT;
    chk_slow_wait: assert property (slow |-> !PREADY ##1 !PREADY ##1 PREADY)
        else $error("slow access answered at the wrong cycle");
    chk_fast_wait: assert property (start && !slow |-> !PREADY ##1 PREADY)
        else $error("register access answered at the wrong cycle");
    chk_unmapped_err: assert property (start && !mapped |-> ##1 PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped address not refused");
    chk_good_op: assert property (instr_wr && good_op |-> ##2 PREADY && !PSLVERR)
        else $error("supported instruction refused");
    chk_mapped_ok: assert property (start && mapped && !instr_wr |-> ##1 !PSLVERR)
        else $error("mapped access refused");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    chk_err_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error outside an answered access");
    chk_rdata_hold: assert property (!$stable(PRDATA) |-> $past(PENABLE))
        else $error("read data changed outside an access");
    cover property (instr_wr ##2 PREADY);
    cover property (start && !mapped);
    cover property (PREADY && PSLVERR && PADDR == bat_pkg::OFS_INSTR);
endmodule
bind bat_alu_top bat_alu_properties u_props (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// ### dv/bat_alu_top_test.sv
// Purpose: Self-checking bench for bat_alu_top through its APB registers.
// Assumes: Hand-over register map; every transfer is followed by one idle cycle.
// Notes:   Table rows run one instruction each, plus the skipped word after a taken skip; reset and refusals follow.
`timescale 1ns/1ps
module bat_alu_top_test;
    typedef struct packed {
        logic [13:0] iw;
        logic [7:0]  a;
        logic [7:0]  f;
        logic [2:0]  s0;
        logic [7:0]  ea;
        logic [7:0]  ef;
        logic [3:0]  es;
    } bat_row_t;
    logic        MCLK;
    logic        RESET;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    int          num_errors;
    int          n_compared;
    int          cyc;
    bat_row_t    rows [16];
    bat_alu_top uut (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // The answer is taken at the rising edge that samples PREADY high, before that edge updates the design.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                        input logic ee);
        int          n;
        logic [31:0] rd;
        logic        er;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        @(posedge MCLK);
        while (PREADY !== 1'b1 && n < 20) begin
            n++;
            @(posedge MCLK);
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
        if (n == 20) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end
        if (!w)
            chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask
    // Roughly 650 cycles of transfers are expected; the limit allows several times that.
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
    initial begin
        rows = '{'{14'h3e01, 8'h0f, 8'h55, 3'h0, 8'h10, 8'h55, 4'h2},
                 '{14'h3f01, 8'hff, 8'h55, 3'h0, 8'h00, 8'h55, 4'h7},
                 '{14'h072a, 8'h80, 8'h80, 3'h0, 8'h00, 8'h80, 4'h5},
                 '{14'h07aa, 8'h12, 8'h34, 3'h0, 8'h12, 8'h46, 4'h0},
                 '{14'h07ff, 8'h01, 8'h0f, 3'h0, 8'h01, 8'h10, 4'h2},
                 '{14'h390f, 8'hf0, 8'h55, 3'h3, 8'h00, 8'h55, 4'h7},
                 '{14'h05aa, 8'h3c, 8'hf0, 3'h7, 8'h3c, 8'h30, 4'h3},
                 '{14'h052a, 8'hff, 8'ha5, 3'h0, 8'ha5, 8'ha5, 4'h0},
                 '{14'h13aa, 8'h11, 8'hff, 3'h7, 8'h11, 8'h7f, 4'h7},
                 '{14'h102a, 8'h11, 8'h01, 3'h0, 8'h11, 8'h00, 4'h0},
                 '{14'h142a, 8'h11, 8'h00, 3'h0, 8'h11, 8'h01, 4'h0},
                 '{14'h17aa, 8'h11, 8'h7f, 3'h5, 8'h11, 8'hff, 4'h5},
                 '{14'h19aa, 8'h11, 8'hf7, 3'h0, 8'h11, 8'hf7, 4'h8},
                 '{14'h19aa, 8'h11, 8'h08, 3'h7, 8'h11, 8'h08, 4'h7},
                 '{14'h1f2a, 8'h11, 8'h40, 3'h2, 8'h11, 8'h40, 4'ha},
                 '{14'h1f2a, 8'h11, 8'hbf, 3'h0, 8'h11, 8'hbf, 4'h0}};
        num_errors = 0;
        n_compared = 0;
        cyc = 0;
        RESET = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (12) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        foreach (rows[i]) begin
            xfer(1'b1, bat_pkg::OFS_STATUS, {29'h0, rows[i].s0}, 32'h0, 1'b0);
            xfer(1'b1, bat_pkg::OFS_ACC, {24'h0, rows[i].a}, 32'h0, 1'b0);
            xfer(1'b1, bat_pkg::OFS_FADDR, {25'h0, rows[i].iw[6:0]}, 32'h0, 1'b0);
            xfer(1'b1, bat_pkg::OFS_FDATA, {24'h0, rows[i].f}, 32'h0, 1'b0);
            xfer(1'b1, bat_pkg::OFS_INSTR, {18'h0, rows[i].iw}, 32'h0, 1'b0);
            xfer(1'b0, bat_pkg::OFS_ACC, 32'h0, {24'h0, rows[i].ea}, 1'b0);
            xfer(1'b0, bat_pkg::OFS_FDATA, 32'h0, {24'h0, rows[i].ef}, 1'b0);
            xfer(1'b0, bat_pkg::OFS_STATUS, 32'h0, {28'h0, rows[i].es}, 1'b0);
            cyc++;
            // A skipped slot must swallow even an unsupported word without an error.
            if (rows[i].es[3]) begin
                xfer(1'b1, bat_pkg::OFS_INSTR, (i % 4 == 0) ? 32'h0 : 32'h3eff, 32'h0, 1'b0);
                xfer(1'b0, bat_pkg::OFS_ACC, 32'h0, {24'h0, rows[i].ea}, 1'b0);
                xfer(1'b0, bat_pkg::OFS_STATUS, 32'h0, {29'h0, rows[i].es[2:0]}, 1'b0);
                cyc++;
            end
        end
        xfer(1'b0, bat_pkg::OFS_CYCLES, 32'h0, cyc, 1'b0);
        xfer(1'b1, bat_pkg::OFS_INSTR, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, bat_pkg::OFS_ACC, 32'h0, 32'h11, 1'b0);
        xfer(1'b1, 8'h18, 32'h1, 32'h0, 1'b1);
        xfer(1'b0, 8'h05, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, bat_pkg::OFS_STATUS, 32'hf, 32'h0, 1'b0);
        xfer(1'b0, bat_pkg::OFS_STATUS, 32'h0, 32'h7, 1'b0);
        xfer(1'b1, bat_pkg::OFS_CYCLES, 32'h5, 32'h0, 1'b0);
        xfer(1'b0, bat_pkg::OFS_CYCLES, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, bat_pkg::OFS_FADDR, 32'h33, 32'h0, 1'b0);
        RESET <= 1'b1;
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        xfer(1'b0, bat_pkg::OFS_ACC, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, bat_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, bat_pkg::OFS_FADDR, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, bat_pkg::OFS_INSTR, 32'h0, 32'h0, 1'b0);
        give_verdict();
    end
endmodule
